// [hdl/osq_consts.svh]
// Purpose: named constants for the secure-area and quad-mode command block
// Assumes: bits are counted from the first clock of a frame
// Notes: opcodes, defaults and field layouts
`ifndef OSQ_CONSTS_SVH
`define OSQ_CONSTS_SVH
`define OSQ_OP_ERASE 8'h44
`define OSQ_OP_PROG 8'h42
`define OSQ_OP_READ 8'h48
`define OSQ_OP_PARAM 8'hC0
`define OSQ_OP_WRAPRD 8'h0C
`define OSQ_OP_QUAD_ON 8'h38
`define OSQ_OP_QUAD_OFF 8'hFF
`define OSQ_OP_WREN 8'h06
`define OSQ_OP_WRDI 8'h04
`define OSQ_CNT_OP 13'h0008
`define OSQ_CNT_PARAM 13'h0010
`define OSQ_CNT_ADDR 13'h0020
`define OSQ_CNT_RD_DATA 13'h0028
`define OSQ_CNT_PROG_MIN 13'h0028
`define OSQ_CNT_FOLD 13'h0800
`define OSQ_DUMMY_DEF 3'h0
`define OSQ_WRAP_DEF 2'h0
`define OSQ_PAGE_MASK 24'h0000FF
`define OSQ_CLK_MHZ 25
`define OSQ_ERASE_LAST 10'h3FF
`define OSQ_PROG_LAST 10'h0FF
`endif

// [hdl/osq_pkg.sv]
// Purpose: shared types of the secure-area command block
// Assumes: nothing
// Notes: internal operation codes
package osq_pkg;
    typedef enum logic [1:0] {
        OSQ_IDLE = 2'b00,
        OSQ_ERASE = 2'b01,
        OSQ_PROG = 2'b10
    } osq_op_t;
endpackage

// [hdl/osq_cmd.sv]
// Purpose: secure-area erase/program/read, read parameters, quad mode
// Assumes: frame logic clocked by the host serial clock, cs_n frames it
// Notes: link command registers are read by the core at the cs_n rise; the page buffer is read while busy
`timescale 1ns/100ps
`default_nettype none
`include "osq_consts.svh"
module osq_cmd
    import osq_pkg::*;
#(
    parameter int ERASE_TIME_US = 100,
    parameter int PROG_TIME_US = 20
) (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic sck,
    input wire logic cs_n,
    input wire logic [3:0] io_in,
    output logic [3:0] io_out,
    output logic [3:0] io_oe,
    input wire logic otp_lock_bit,
    input wire logic quad_enable_bit,
    input wire logic spi_wrap_load,
    input wire logic [1:0] spi_wrap_field,
    input wire logic soft_reset,
    output logic write_enable_latch,
    output logic in_progress_flag,
    output logic quad_mode,
    output logic [2:0] dummy_select_field,
    output logic [1:0] wrap_size_field,
    output logic [23:0] array_rd_addr,
    input wire logic [7:0] array_rd_data
);
    // cycle counts of the self-timed operations
    localparam int ERASE_CYC = ERASE_TIME_US * `OSQ_CLK_MHZ;
    localparam int PROG_CYC = PROG_TIME_US * `OSQ_CLK_MHZ;
    // refuse times that the 16-bit timer cannot hold
    if (ERASE_CYC < 1 || PROG_CYC < 1
        || ERASE_CYC > 65535 || PROG_CYC > 65535) begin : g_bad_time
        $error("osq_cmd: operation time out of range");
    end

    // decoded dummy clocks times bits per clock in quad mode
    function automatic logic [12:0] dummy_bits(input logic [2:0] sel);
        dummy_bits = {8'h00, sel[1:0], 3'b000} + 13'h0008;
    endfunction

    // secure storage, four pages of 256 bytes
    logic [7:0] otp_mem [0:1023];

    // ---------------- link domain (host serial clock) ----------------
    logic started_reg; // a clock has been seen in this frame
    logic frame_tgl_reg; // flips once per clocked frame
    logic [12:0] cnt_reg; // bits received in this frame
    logic [31:0] sh_reg; // input shift register
    logic [7:0] opcode_reg;
    logic [23:0] addr_reg;
    logic [7:0] param_reg;
    logic rd_en_reg; // read data phase allowed
    logic prog_en_reg; // program bytes accepted
    logic [23:0] rd_ptr_reg;
    logic [7:0] pg_ptr_reg;
    logic [7:0] tx_reg; // byte being shifted out
    logic tx_valid_reg;
    logic [7:0] prog_buf [0:255];
    logic [255:0] prog_mask_reg; // which buffer bytes were loaded
    logic bsy_s1_reg, bsy_s2_reg, bsy_s3_reg, busy_seen_reg;

    wire [12:0] step = quad_mode ? 13'h0004 : 13'h0001;
    wire [12:0] cnt_base = started_reg ? cnt_reg : 13'h0000;
    wire [12:0] cnt_sum = cnt_base + step;
    // long reads fold the count back by a multiple of eight to keep phase
    wire [12:0] cnt_new = cnt_sum[12] ? cnt_sum - `OSQ_CNT_FOLD : cnt_sum;
    wire [31:0] sh_new = quad_mode ? {sh_reg[27:0], io_in} : {sh_reg[30:0], io_in[0]};
    wire op_is_read = (opcode_reg == `OSQ_OP_READ) && !quad_mode;
    wire op_is_wrap = (opcode_reg == `OSQ_OP_WRAPRD) && quad_mode;
    wire rd_addr_ok = op_is_wrap || (sh_new[23:10] == 14'h0000);
    wire [12:0] data_start = op_is_read ? `OSQ_CNT_RD_DATA :
        `OSQ_CNT_ADDR + dummy_bits(dummy_select_field);
    wire rd_load = rd_en_reg && (cnt_new >= data_start) && (cnt_new[2:0] == 3'b000);
    wire [23:0] wrap_mask = op_is_read ? `OSQ_PAGE_MASK :
        ({16'h0000, 8'h08} << wrap_size_field) - 24'h000001;
    wire [23:0] rd_ptr_inc = (rd_ptr_reg & ~wrap_mask) |
        ((rd_ptr_reg + 24'h000001) & wrap_mask);
    wire [7:0] rd_src = op_is_read ? otp_mem[rd_ptr_reg[9:0]] : array_rd_data;
    wire prog_byte = prog_en_reg && (cnt_new > `OSQ_CNT_ADDR) && (cnt_new[2:0] == 3'b000);

    // frame start flag, cleared whenever chip select is high or on reset
    always_ff @(posedge sck or posedge cs_n or posedge rst) begin
        if (cs_n || rst) begin
            started_reg <= 1'b0;
        end else begin
            started_reg <= 1'b1;
        end
    end

    // busy flag into the link domain, a change counts once s2 and s3 agree
    always_ff @(posedge sck or posedge rst) begin
        if (rst) begin
            bsy_s1_reg <= 1'b0;
            bsy_s2_reg <= 1'b0;
            bsy_s3_reg <= 1'b0;
            busy_seen_reg <= 1'b0;
        end else begin
            bsy_s1_reg <= in_progress_flag;
            bsy_s2_reg <= bsy_s1_reg;
            bsy_s3_reg <= bsy_s2_reg;
            if (bsy_s2_reg == bsy_s3_reg) begin
                busy_seen_reg <= bsy_s3_reg;
            end
        end
    end

    // command, address and parameter capture on rising edges
    always_ff @(posedge sck or posedge rst) begin
        if (rst) begin
            frame_tgl_reg <= 1'b0;
            cnt_reg <= 13'h0000;
            sh_reg <= 32'h00000000;
            opcode_reg <= 8'h00;
            addr_reg <= 24'h000000;
            param_reg <= 8'h00;
        end else begin
            if (!started_reg) begin
                frame_tgl_reg <= ~frame_tgl_reg;
            end
            cnt_reg <= cnt_new;
            sh_reg <= sh_new;
            if (cnt_new == `OSQ_CNT_OP) begin
                opcode_reg <= sh_new[7:0];
            end
            if (cnt_new == `OSQ_CNT_PARAM) begin
                param_reg <= sh_new[7:0];
            end
            if (cnt_new == `OSQ_CNT_ADDR) begin
                addr_reg <= sh_new[23:0];
            end
        end
    end

    // read pointer and transmit byte
    always_ff @(posedge sck or posedge rst) begin
        if (rst) begin
            rd_en_reg <= 1'b0;
            rd_ptr_reg <= 24'h000000;
            tx_reg <= 8'h00;
            tx_valid_reg <= 1'b0;
        end else begin
            // first clock of a frame drops a byte left over from the last read
            if (!started_reg || cnt_new == `OSQ_CNT_OP) begin
                rd_en_reg <= 1'b0;
                tx_valid_reg <= 1'b0;
            end else if (cnt_new == `OSQ_CNT_ADDR) begin
                // ignored while busy or on a bad address
                rd_en_reg <= (op_is_read || op_is_wrap) && !busy_seen_reg && rd_addr_ok;
                rd_ptr_reg <= sh_new[23:0];
            end else if (rd_load) begin
                tx_reg <= rd_src;
                tx_valid_reg <= 1'b1;
                rd_ptr_reg <= rd_ptr_inc;
            end
        end
    end

    // program page buffer filled during the frame
    always_ff @(posedge sck or posedge rst) begin
        if (rst) begin
            prog_en_reg <= 1'b0;
            pg_ptr_reg <= 8'h00;
            prog_mask_reg <= '0;
        end else begin
            if (cnt_new == `OSQ_CNT_OP) begin
                prog_en_reg <= 1'b0;
                // a fresh program clears the buffer, status polls leave it
                if (sh_new[7:0] == `OSQ_OP_PROG && !busy_seen_reg) begin
                    prog_mask_reg <= '0;
                end
            end else if (cnt_new == `OSQ_CNT_ADDR) begin
                prog_en_reg <= (opcode_reg == `OSQ_OP_PROG) && !quad_mode && !busy_seen_reg;
                pg_ptr_reg <= sh_new[7:0];
            end else if (prog_byte) begin
                prog_mask_reg[pg_ptr_reg] <= 1'b1;
                pg_ptr_reg <= pg_ptr_reg + 8'h01;
            end
        end
    end

    // buffer storage has no reset
    always_ff @(posedge sck) begin
        if (prog_byte) begin
            prog_buf[pg_ptr_reg] <= sh_new[7:0];
        end
    end

    // data out on falling edges, MSB first, released by cs_n
    always_ff @(negedge sck or posedge cs_n) begin
        if (cs_n) begin
            io_out <= 4'h0;
            io_oe <= 4'h0;
        end else if (tx_valid_reg && quad_mode) begin
            io_out <= cnt_reg[2] ? tx_reg[3:0] : tx_reg[7:4];
            io_oe <= 4'hF;
        end else if (tx_valid_reg) begin
            io_out <= {2'b00, tx_reg[3'd7 - cnt_reg[2:0]], 1'b0};
            io_oe <= 4'b0010;
        end else begin
            io_out <= 4'h0;
            io_oe <= 4'h0;
        end
    end

    assign array_rd_addr = rd_ptr_reg;

    // ---------------- core domain ----------------
    logic cs_s1_reg, cs_s2_reg, cs_s3_reg, cs_level_reg;
    logic seen_tgl_reg; // last frame already acted on
    logic wel_reg, quad_reg, busy_reg;
    logic [2:0] dummy_reg;
    logic [1:0] wrap_reg;
    osq_op_t op_reg;
    logic [15:0] timer_reg;
    logic [9:0] walk_reg;
    logic walk_done_reg;
    logic [1:0] page_reg;

    // chip select rise seen once two later stages agree
    wire cs_rise = cs_s2_reg && cs_s3_reg && !cs_level_reg;
    wire frame_end = cs_rise && (frame_tgl_reg != seen_tgl_reg);
    wire op_spi = frame_end && !quad_reg;
    wire op_quad = frame_end && quad_reg;
    wire cnt8 = cnt_reg == `OSQ_CNT_OP;
    wire do_wren = frame_end && cnt8 && opcode_reg == `OSQ_OP_WREN && !busy_reg;
    wire do_wrdi = frame_end && cnt8 && opcode_reg == `OSQ_OP_WRDI && !busy_reg;
    wire do_erase = op_spi && opcode_reg == `OSQ_OP_ERASE && cnt_reg == `OSQ_CNT_ADDR
        && wel_reg && !otp_lock_bit && !busy_reg
        && addr_reg[23:8] == 16'h0000;
    wire do_prog = op_spi && opcode_reg == `OSQ_OP_PROG && cnt_reg >= `OSQ_CNT_PROG_MIN
        && cnt_reg[2:0] == 3'b000 && wel_reg && !otp_lock_bit && !busy_reg
        && addr_reg[23:10] == 14'h0000;
    wire do_param = op_quad && opcode_reg == `OSQ_OP_PARAM
        && cnt_reg == `OSQ_CNT_PARAM && !param_reg[6];
    wire do_qon = op_spi && cnt8 && opcode_reg == `OSQ_OP_QUAD_ON
        && quad_enable_bit;
    wire do_qoff = op_quad && cnt8 && opcode_reg == `OSQ_OP_QUAD_OFF;
    wire op_last = (op_reg == OSQ_ERASE) ? walk_reg == `OSQ_ERASE_LAST
        : walk_reg == `OSQ_PROG_LAST;
    wire op_finish = busy_reg && timer_reg == 16'h0000 && walk_done_reg;

    // chip select synchroniser
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            cs_s1_reg <= 1'b1;
            cs_s2_reg <= 1'b1;
            cs_s3_reg <= 1'b1;
            cs_level_reg <= 1'b1;
            seen_tgl_reg <= 1'b0;
        end else begin
            cs_s1_reg <= cs_n;
            cs_s2_reg <= cs_s1_reg;
            cs_s3_reg <= cs_s2_reg;
            if (cs_s2_reg == cs_s3_reg) begin
                cs_level_reg <= cs_s3_reg;
            end
            if (cs_rise) begin
                seen_tgl_reg <= frame_tgl_reg;
            end
        end
    end

    // mode and read parameter state
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            quad_reg <= 1'b0;
            dummy_reg <= `OSQ_DUMMY_DEF;
            wrap_reg <= `OSQ_WRAP_DEF;
        end else if (soft_reset) begin
            quad_reg <= 1'b0;
            dummy_reg <= `OSQ_DUMMY_DEF;
            wrap_reg <= `OSQ_WRAP_DEF;
        end else begin
            if (do_qon) begin
                quad_reg <= 1'b1; // wrap kept
            end else if (do_qoff) begin
                quad_reg <= 1'b0;
            end
            if (do_param) begin
                dummy_reg <= param_reg[6:4];
                wrap_reg <= param_reg[1:0];
            end else if (spi_wrap_load && !quad_reg) begin
                wrap_reg <= spi_wrap_field;
            end
        end
    end

    // write enable latch; set beats a completion clear
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            wel_reg <= 1'b0;
        end else if (soft_reset || do_wrdi) begin
            wel_reg <= 1'b0;
        end else if (do_wren) begin
            wel_reg <= 1'b1;
        end else if (op_finish) begin
            wel_reg <= 1'b0;
        end
    end

    // self-timed erase and program engine
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            busy_reg <= 1'b0;
            op_reg <= OSQ_IDLE;
            timer_reg <= 16'h0000;
            walk_reg <= 10'h000;
            walk_done_reg <= 1'b0;
            page_reg <= 2'b00;
        end else if (do_erase || do_prog) begin
            busy_reg <= 1'b1;
            op_reg <= do_erase ? OSQ_ERASE : OSQ_PROG;
            timer_reg <= do_erase ? 16'(ERASE_CYC - 1) : 16'(PROG_CYC - 1);
            walk_reg <= 10'h000;
            walk_done_reg <= 1'b0;
            page_reg <= addr_reg[9:8];
        end else if (busy_reg) begin
            if (timer_reg != 16'h0000) begin
                timer_reg <= timer_reg - 16'h0001;
            end
            if (!walk_done_reg) begin
                walk_done_reg <= op_last;
                walk_reg <= walk_reg + 10'h001;
            end
            if (op_finish) begin
                busy_reg <= 1'b0;
                op_reg <= OSQ_IDLE;
            end
        end
    end

    // storage update: erase sets all bytes, program clears bits only
    always_ff @(posedge core_clk) begin
        if (busy_reg && !walk_done_reg) begin
            unique case (op_reg)
                OSQ_ERASE: begin
                    otp_mem[walk_reg] <= 8'hFF;
                end
                OSQ_PROG: begin
                    if (prog_mask_reg[walk_reg[7:0]]) begin
                        otp_mem[{page_reg, walk_reg[7:0]}] <=
                            otp_mem[{page_reg, walk_reg[7:0]}] & prog_buf[walk_reg[7:0]];
                    end
                end
                OSQ_IDLE: begin
                end
            endcase
        end
    end

    assign write_enable_latch = wel_reg;
    assign in_progress_flag = busy_reg;
    assign quad_mode = quad_reg;
    assign dummy_select_field = dummy_reg;
    assign wrap_size_field = wrap_reg;
endmodule
`default_nettype wire

// [verif/osq_cmd_assertions.sv]
// Purpose: port checks of the secure-area and quad-mode command block
// Assumes: sampled on core_clk, rst asynchronous active high
// Notes: bound onto osq_cmd from the bench top
`timescale 1ns/100ps
`default_nettype none
module osq_cmd_assertions #(
    parameter int ERASE_TIME_US = 100,
    parameter int PROG_TIME_US = 20
) (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic cs_n,
    input wire logic [3:0] io_oe,
    input wire logic otp_lock_bit,
    input wire logic quad_enable_bit,
    input wire logic spi_wrap_load,
    input wire logic soft_reset,
    input wire logic write_enable_latch,
    input wire logic in_progress_flag,
    input wire logic quad_mode,
    input wire logic [2:0] dummy_select_field,
    input wire logic [1:0] wrap_size_field
);
    localparam int BUSY_LIM = 25 * (ERASE_TIME_US + PROG_TIME_US) + 1100;
    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);
    logic [15:0] busy_cnt_reg; // cycles spent busy so far
    // count busy cycles so a hung operation is caught
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            busy_cnt_reg <= 16'h0000;
        end else begin
            busy_cnt_reg <= in_progress_flag ? busy_cnt_reg + 16'h0001 : 16'h0000;
        end
    end
    property p_oe_off; cs_n && $past(cs_n) |-> io_oe == 4'h0; endproperty
    a_oe_off: assert property (p_oe_off) else $error("pads driven while idle");
    property p_oe_mode; io_oe != 4'h0 |-> io_oe == (quad_mode ? 4'hF : 4'h2); endproperty
    a_oe_mode: assert property (p_oe_mode) else $error("pad enables off mode");
    property p_quad_gate; $rose(quad_mode) |-> $past(quad_enable_bit); endproperty
    a_quad_gate: assert property (p_quad_gate) else $error("quad without enable");
    property p_busy_gate;
        $rose(in_progress_flag) |-> $past(write_enable_latch) && !$past(otp_lock_bit);
    endproperty
    a_busy_gate: assert property (p_busy_gate) else $error("busy not allowed");
    property p_wel_clear; $fell(in_progress_flag) |-> !write_enable_latch; endproperty
    a_wel_clear: assert property (p_wel_clear) else $error("latch kept at end");
    property p_busy_min; $rose(in_progress_flag) |-> in_progress_flag [*8]; endproperty
    a_busy_min: assert property (p_busy_min) else $error("busy too short");
    property p_busy_max; in_progress_flag |-> busy_cnt_reg < BUSY_LIM; endproperty
    a_busy_max: assert property (p_busy_max) else $error("busy too long");
    property p_dummy_src;
        $changed(dummy_select_field) |-> $past(quad_mode) || $past(soft_reset);
    endproperty
    a_dummy_src: assert property (p_dummy_src) else $error("dummy set in serial");
    property p_dummy_ok; dummy_select_field[2] == 1'b0; endproperty
    a_dummy_ok: assert property (p_dummy_ok) else $error("dummy code illegal");
    property p_mode_keep;
        $changed(quad_mode) && !$past(soft_reset) |->
            $stable(wrap_size_field) && $stable(write_enable_latch);
    endproperty
    a_mode_keep: assert property (p_mode_keep) else $error("mode switch lost state");
    property p_soft;
        soft_reset |=> !quad_mode && !write_enable_latch && dummy_select_field == 3'h0
            && wrap_size_field == 2'h0;
    endproperty
    a_soft: assert property (p_soft) else $error("defaults not restored");
    property p_wrap_src;
        $changed(wrap_size_field) |-> $past(quad_mode) || $past(spi_wrap_load)
            || $past(soft_reset);
    endproperty
    a_wrap_src: assert property (p_wrap_src) else $error("wrap changed alone");
    c_quad: cover property ($rose(quad_mode));
    c_erase: cover property ($fell(in_progress_flag));
    c_qread: cover property (io_oe == 4'hF);
endmodule
`default_nettype wire

// [verif/osq_host_model.sv]
// Purpose: host controller model driving the link pins
// Assumes: sck idles low, runs only inside frames, 48 ns period
// Notes: replies sampled on rising sck, one frame per call
`timescale 1ns/100ps
`default_nettype none
module osq_host_model (
    output logic sck,
    output logic cs_n,
    output logic [3:0] io_in,
    input wire logic [3:0] io_out,
    input wire logic [3:0] io_oe
);
    logic drove; // device enabled a pad during the last frame
    initial begin
        sck = 1'b0;
        cs_n = 1'b1;
        io_in = 4'h5;
        drove = 1'b0;
    end
    // n clocks, serial or quad, tx msb first, rx gathers replies
    task automatic frame(input int n, input logic q, input logic [63:0] tx,
        output logic [63:0] rx);
        rx = '0;
        drove = 1'b0;
        cs_n = 1'b0;
        #24;
        for (int i = 0; i < n; i++) begin
            io_in = q ? tx[63:60] : {~io_in[3:1], tx[63]};
            tx = q ? tx << 4 : tx << 1;
            #24 sck = 1'b1;
            rx = q ? {rx[59:0], io_out} : {rx[62:0], io_out[1]};
            drove = drove | (|io_oe);
            #24 sck = 1'b0;
        end
        #24 cs_n = 1'b1; // raised half a period after the last clock, whatever n is
        io_in = ~io_in; // released lines show no stale value
        #240;
    endtask
endmodule
`default_nettype wire

// [verif/osq_cmd_tb_top.sv]
// Purpose: self-checking bench of the secure-area and quad-mode block
// Assumes: short busy times, host model drives the link
// Notes: lfsr picks data bytes, addresses and read parameters
`timescale 1ns/100ps
`default_nettype none
module osq_cmd_tb_top;
    localparam int ERASE_TIME_US = 1;
    localparam int PROG_TIME_US = 1;
    logic core_clk = 1'b0;
    logic rst = 1'b0;
    wire logic sck;
    wire logic cs_n;
    wire logic [3:0] io_in;
    logic [3:0] io_out, io_oe;
    logic otp_lock_bit = 1'b0;
    logic quad_enable_bit = 1'b0;
    logic spi_wrap_load = 1'b0;
    logic soft_reset = 1'b0;
    logic [1:0] spi_wrap_field = 2'h0;
    logic write_enable_latch, in_progress_flag, quad_mode;
    logic [2:0] dummy_select_field;
    logic [1:0] wrap_size_field;
    logic [23:0] array_rd_addr;
    wire logic [7:0] array_rd_data;
    logic [63:0] rx;
    logic [31:0] rnd = 32'h1A1A;
    logic [1:0] w;
    int fail_count = 0;
    int checked = 0;
    always #20 core_clk = ~core_clk;
    function automatic logic [7:0] arr_byte(input logic [23:0] a);
        return a[7:0] ^ 8'h5A;
    endfunction
    assign array_rd_data = arr_byte(array_rd_addr);
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    // four burst bytes from a, wrapping inside 8 << wc bytes
    function automatic logic [31:0] wrap4(input logic [23:0] a, input logic [1:0] wc);
        logic [23:0] m;
        m = (24'h8 << wc) - 24'h1;
        for (int k = 0; k < 4; k++) begin
            wrap4 = {wrap4[23:0], arr_byte((a & ~m) | ((a + k) & m))};
        end
    endfunction
    osq_cmd #(.ERASE_TIME_US(ERASE_TIME_US), .PROG_TIME_US(PROG_TIME_US)) osq_cmd_i (
        .core_clk, .rst, .sck, .cs_n, .io_in, .io_out, .io_oe, .otp_lock_bit,
        .quad_enable_bit, .spi_wrap_load, .spi_wrap_field, .soft_reset,
        .write_enable_latch, .in_progress_flag, .quad_mode, .dummy_select_field,
        .wrap_size_field, .array_rd_addr, .array_rd_data);
    osq_host_model osq_host_model_i (.sck, .cs_n, .io_in, .io_out, .io_oe);
    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        checked++;
        if (got !== exp) begin
            fail_count++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic cmd(input int n, input logic q, input logic [31:0] hd, input logic [31:0] tl);
        @(posedge core_clk);
        #5;
        osq_host_model_i.frame(n, q, {hd, tl}, rx);
    endtask
    task automatic wait_idle();
        for (int i = 0; i < 4000 && in_progress_flag !== 1'b0; i++) begin
            @(posedge core_clk);
        end
        #1;
    endtask
    task automatic close_out();
        $display("mismatches=%0d comparisons=%0d", fail_count, checked);
        if (fail_count == 0 && checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    initial begin
        #2000000;
        fail_count++;
        close_out();
    end
    initial begin
        rst <= 1'b1; // a real edge, so link-side registers reset too
        repeat (20) @(posedge core_clk);
        rst <= 1'b0;
        repeat (5) @(posedge core_clk);
        #1;
        chk({write_enable_latch, in_progress_flag, quad_mode, dummy_select_field,
            wrap_size_field}, 8'h00);
        cmd(32, 1'b0, 32'h44000000, 32'h0);
        chk(in_progress_flag, 1'b0);
        cmd(8, 1'b0, 32'h06000000, 32'h0);
        cmd(33, 1'b0, 32'h44000000, 32'h0);
        chk(in_progress_flag, 1'b0);
        cmd(32, 1'b0, 32'h44000100, 32'h0);
        chk(in_progress_flag, 1'b0);
        cmd(32, 1'b0, 32'h44000000, 32'h0);
        chk({in_progress_flag, write_enable_latch}, 2'b11);
        cmd(48, 1'b0, 32'h48000000, 32'h0);
        chk(osq_host_model_i.drove, 1'b0);
        wait_idle();
        chk({in_progress_flag, write_enable_latch}, 2'b00);
        rnd = lfsr(rnd);
        cmd(8, 1'b0, 32'h06000000, 32'h0);
        cmd(48, 1'b0, 32'h420001FF, {rnd[15:0], 16'h0});
        wait_idle();
        chk(write_enable_latch, 1'b0);
        cmd(64, 1'b0, 32'h480001FE, 32'h0);
        chk(rx[23:0], {8'hFF, rnd[15:0]});
        // address above the page field: read refused, pads stay off
        cmd(48, 1'b0, 32'h48000400, 32'h0);
        chk(osq_host_model_i.drove, 1'b0);
        @(posedge core_clk);
        otp_lock_bit <= 1'b1;
        cmd(8, 1'b0, 32'h06000000, 32'h0);
        cmd(32, 1'b0, 32'h44000000, 32'h0);
        cmd(48, 1'b0, 32'h420001FF, 32'h0);
        chk(in_progress_flag, 1'b0);
        cmd(16, 1'b0, 32'hC0370000, 32'h0);
        chk(dummy_select_field, 3'h0);
        rnd = lfsr(rnd);
        w = rnd[1:0] | 2'h1;
        @(posedge core_clk);
        spi_wrap_field <= w;
        spi_wrap_load <= 1'b1;
        @(posedge core_clk);
        spi_wrap_load <= 1'b0;
        cmd(8, 1'b0, 32'h38000000, 32'h0);
        chk(quad_mode, 1'b0);
        @(posedge core_clk);
        quad_enable_bit <= 1'b1;
        cmd(8, 1'b0, 32'h38000000, 32'h0);
        chk({quad_mode, wrap_size_field, write_enable_latch}, {1'b1, w, 1'b1});
        for (int k = 0; k < 4; k++) begin
            rnd = lfsr(rnd);
            cmd(4, 1'b1, {8'hC0, rnd[7], 1'b0, k[1:0], rnd[3:2], ~k[1:0], 16'h0}, 32'h0);
            chk({dummy_select_field, wrap_size_field}, {1'b0, k[1:0], ~k[1:0]});
            cmd(18 + 2 * k, 1'b1, {8'h0C, rnd[31:8]}, 32'h0);
            chk(rx[31:0], wrap4(rnd[31:8], ~k[1:0]));
        end
        cmd(4, 1'b1, 32'hC0400000, 32'h0);
        chk(dummy_select_field, 3'h3);
        cmd(2, 1'b1, 32'hFF000000, 32'h0);
        chk({quad_mode, write_enable_latch, wrap_size_field}, 4'h4);
        @(posedge core_clk);
        spi_wrap_load <= 1'b1; // nonzero wrap so the default restore shows
        @(posedge core_clk);
        spi_wrap_load <= 1'b0;
        soft_reset <= 1'b1;
        @(posedge core_clk);
        soft_reset <= 1'b0;
        @(posedge core_clk);
        #1;
        chk({write_enable_latch, dummy_select_field, wrap_size_field}, 6'h00);
        close_out();
    end
endmodule
bind osq_cmd osq_cmd_assertions #(.ERASE_TIME_US(ERASE_TIME_US), .PROG_TIME_US(PROG_TIME_US))
    osq_cmd_assertions_i (.core_clk, .rst, .cs_n, .io_oe, .otp_lock_bit, .quad_enable_bit,
    .spi_wrap_load, .soft_reset, .write_enable_latch, .in_progress_flag, .quad_mode,
    .dummy_select_field, .wrap_size_field);
`default_nettype wire
